//--- shared/ifaaf_defines.svh
// Register offsets, field positions, reset values and counts for the IF front end
`ifndef IFAAF_DEFINES_SVH
`define IFAAF_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define IFAAF_ADDR_STANDBY 7'h00
`define IFAAF_ADDR_BIAS 7'h01
`define IFAAF_ADDR_ATTN 7'h03
`define IFAAF_ADDR_AGC_REF 7'h06
`define IFAAF_ADDR_REF_HI 7'h10
`define IFAAF_ADDR_REF_LO 7'h11
`define IFAAF_ADDR_FB_HI 7'h12
`define IFAAF_ADDR_FB_LO 7'h13
`define IFAAF_ADDR_PUMP 7'h14
`define IFAAF_ADDR_FA_HI 7'h15
`define IFAAF_ADDR_FA_LO 7'h16
`define IFAAF_ADDR_FILT_RESP 7'h1c
`define IFAAF_ADDR_NEG_CAP 7'h1d
`define IFAAF_ADDR_POS_CAP 7'h1e

// ----------------------------------------
// Reset values
// ----------------------------------------
`define IFAAF_RST_STANDBY 8'hff
`define IFAAF_RST_REF_LO 8'h38
`define IFAAF_RST_FB_LO 8'h3c
`define IFAAF_RST_FA_LO 8'h04
`define IFAAF_RST_FILT_RESP 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IFAAF_SBY_VGA_BIT 2
`define IFAAF_SBY_ADC_BIT 3
`define IFAAF_SBY_CK_BIT 5
`define IFAAF_AMP_BIAS_HI 7
`define IFAAF_AMP_BIAS_LO 6
`define IFAAF_MIX_BIAS_HI 5
`define IFAAF_MIX_BIAS_LO 4
`define IFAAF_OSC_BIAS_HI 3
`define IFAAF_OSC_BIAS_LO 2
`define IFAAF_ATTN_BIT 7
`define IFAAF_PUMP_FAST_BIT 6
`define IFAAF_PUMP_POL_BIT 5
`define IFAAF_PUMP_CUR_HI 4
`define IFAAF_PUMP_CUR_LO 2
`define IFAAF_PUMP_TEST_BIT 0
`define IFAAF_CAP_ERR_BIT 5

// ----------------------------------------
// Serial frame and tuning counts
// ----------------------------------------
`define IFAAF_FRAME_BITS 5'd16
`define IFAAF_ADDR_DONE_CNT 5'd7
`define IFAAF_DATA_START_CNT 5'd8
`define IFAAF_SHIFT_START_CNT 5'd9
`define IFAAF_LAST_BIT_CNT 5'd15
`define IFAAF_CAP_MAX 5'd31

`endif

//--- shared/ifaaf_pkg.sv
// Types shared by the IF front end design files
package ifaaf_pkg;
	typedef enum logic [1:0] {TUNE_IDLE, TUNE_MEASURE, TUNE_COMPUTE} ifaaf_tune_state_t;
	typedef logic [4:0] ifaaf_cap_t;
endpackage

//--- hw/ifaaf_spi_slave.sv
// Serial peripheral port slave: 16-bit frames, read/write flag, 7-bit address, 8-bit data
`timescale 1ns/100ps
`include "ifaaf_defines.svh"
module ifaaf_spi_slave
	import ifaaf_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_spi_cs_n,
	input wire logic i_spi_clk,
	input wire logic i_spi_mosi,
	input wire logic [7:0] i_rdata,
	output logic [6:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_wr,
	output logic o_miso,
	output logic o_miso_oe
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [1:0] cs_sync_reg, clk_sync_reg, mosi_sync_reg;
	logic clk_dly_reg;
	logic cs_act, clk_rise, clk_fall, mosi_s;

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cs_sync_reg <= 2'h3;
			clk_sync_reg <= 2'h0;
			mosi_sync_reg <= 2'h0;
			clk_dly_reg <= 1'b0;
		end
		else
		begin
			cs_sync_reg <= {cs_sync_reg[0], i_spi_cs_n};
			clk_sync_reg <= {clk_sync_reg[0], i_spi_clk};
			mosi_sync_reg <= {mosi_sync_reg[0], i_spi_mosi};
			clk_dly_reg <= clk_sync_reg[1];
		end
	end

	assign cs_act = ~cs_sync_reg[1];
	assign mosi_s = mosi_sync_reg[1];
	assign clk_rise = cs_act & clk_sync_reg[1] & ~clk_dly_reg;
	assign clk_fall = cs_act & ~clk_sync_reg[1] & clk_dly_reg;

	// ----------------------------------------
	// Frame engine
	// ----------------------------------------
	logic [4:0] cnt_reg, cnt_next;
	logic [6:0] sh_reg, sh_next, addr_reg, addr_next;
	logic rd_reg, rd_next, load_reg, load_next, wr_reg, wr_next;
	logic [7:0] out_reg, out_next, wdata_reg, wdata_next;

	always_comb
	begin
		cnt_next = cnt_reg;
		sh_next = sh_reg;
		addr_next = addr_reg;
		rd_next = rd_reg;
		load_next = 1'b0;
		wr_next = 1'b0;
		out_next = out_reg;
		wdata_next = wdata_reg;
		if (!cs_act)
			cnt_next = 5'h00;
		else if (clk_rise && cnt_reg < `IFAAF_FRAME_BITS)
		begin
			cnt_next = cnt_reg + 5'h01;
			sh_next = {sh_reg[5:0], mosi_s};
			if (cnt_reg == `IFAAF_ADDR_DONE_CNT)
			begin
				// Address known: fetch read data before the next falling edge
				rd_next = sh_reg[6];
				addr_next = {sh_reg[5:0], mosi_s};
				load_next = 1'b1;
			end
			if (cnt_reg == `IFAAF_LAST_BIT_CNT && !rd_reg)
			begin
				wr_next = 1'b1;
				wdata_next = {sh_reg, mosi_s};
			end
		end
		else if (clk_fall && cnt_reg >= `IFAAF_SHIFT_START_CNT)
			out_next = {out_reg[6:0], 1'b0};
		if (load_reg)
			out_next = i_rdata;
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cnt_reg <= 5'h00;
			sh_reg <= 7'h00;
			addr_reg <= 7'h00;
			rd_reg <= 1'b0;
			load_reg <= 1'b0;
			wr_reg <= 1'b0;
			out_reg <= 8'h00;
			wdata_reg <= 8'h00;
		end
		else
		begin
			cnt_reg <= cnt_next;
			sh_reg <= sh_next;
			addr_reg <= addr_next;
			rd_reg <= rd_next;
			load_reg <= load_next;
			wr_reg <= wr_next;
			out_reg <= out_next;
			wdata_reg <= wdata_next;
		end
	end

	assign o_addr = addr_reg;
	assign o_wdata = wdata_reg;
	assign o_wr = wr_reg;
	assign o_miso = out_reg[7];
	assign o_miso_oe = cs_act & rd_reg & (cnt_reg >= `IFAAF_DATA_START_CNT);
endmodule

//--- hw/ifaaf_rc_meter.sv
// Counts on-chip RC oscillator edges over a fixed window of sampling-clock cycles
`timescale 1ns/100ps
module ifaaf_rc_meter
	import ifaaf_pkg::*;
#(
	parameter int WINDOW_CYCLES = 256,
	parameter int COUNT_W = 12
)
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_start,
	input wire logic i_rc_osc,
	output logic [COUNT_W-1:0] o_count,
	output logic o_done,
	output logic o_active
);
	localparam logic [COUNT_W-1:0] WIN_LAST = COUNT_W'(WINDOW_CYCLES - 1);

	logic [1:0] osc_sync_reg;
	logic osc_dly_reg;
	logic [COUNT_W-1:0] win_reg, win_next, edges_reg, edges_next;
	logic act_reg, act_next, done_reg, done_next;
	logic osc_rise;

	assign osc_rise = osc_sync_reg[1] & ~osc_dly_reg;

	// ----------------------------------------
	// Window counter
	// ----------------------------------------
	always_comb
	begin
		win_next = win_reg;
		edges_next = edges_reg;
		act_next = act_reg;
		done_next = 1'b0;
		if (i_start)
		begin
			// Restart discards any window in progress
			win_next = '0;
			edges_next = '0;
			act_next = 1'b1;
		end
		else if (act_reg)
		begin
			win_next = win_reg + 1'b1;
			// Saturate so a fast oscillator cannot wrap to a small count
			if (osc_rise && edges_reg != '1)
				edges_next = edges_reg + 1'b1;
			if (win_reg == WIN_LAST)
			begin
				act_next = 1'b0;
				done_next = 1'b1;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			osc_sync_reg <= 2'h0;
			osc_dly_reg <= 1'b0;
			win_reg <= '0;
			edges_reg <= '0;
			act_reg <= 1'b0;
			done_reg <= 1'b0;
		end
		else
		begin
			osc_sync_reg <= {osc_sync_reg[0], i_rc_osc};
			osc_dly_reg <= osc_sync_reg[1];
			win_reg <= win_next;
			edges_reg <= edges_next;
			act_reg <= act_next;
			done_reg <= done_next;
		end
	end

	assign o_count = edges_reg;
	assign o_done = done_reg;
	assign o_active = act_reg;
endmodule

//--- hw/ifaaf_top.sv
// IF front end configuration registers and antialias filter tuning engine
//
// Summary of operation
// - A write to the filter response register starts a tuning run.
// - Response register resets to zero; writing zero locks it until reset.
// - Tuning counts RC oscillator edges against the sampling clock.
// - Measurement and response code yield two 5-bit capacitor codes.
// - Unreachable codes saturate at range limits and set that array's error flag.
// - Cutoff is sampling clock over 3.2, times 0x60 over response code.
// - Four bias settings drive the clock oscillator core.
// - Clock synthesizer standby bit disables the on-chip clock synthesizer.
// - Amplifier bias in bits 7:6, mixer bias in bits 5:4 of 0x01.
// - Gain amplifier runs in host or automatic gain mode, off in standby.
// - Clock synthesizer uses a 14-bit reference and 13-bit feedback divider.
// - Pump current equals pump code plus one, in 0.625 mA steps.
`timescale 1ns/100ps
`include "ifaaf_defines.svh"
module ifaaf_top
	import ifaaf_pkg::*;
#(
	parameter int WINDOW_CYCLES = 256,
	parameter int COUNT_W = 12,
	parameter int POS_SHIFT = 6,
	parameter int NEG_SHIFT = 7,
	parameter int POS_OFFSET = 4,
	parameter int NEG_OFFSET = 4
)
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_spi_cs_n,
	input wire logic i_spi_clk,
	input wire logic i_spi_mosi,
	output logic o_spi_miso,
	output logic o_spi_miso_oe,
	input wire logic i_rc_osc,
	output logic o_rc_osc_enable,
	output logic o_tuning_busy,
	output logic [7:0] o_standby_control,
	output logic o_adc_enable,
	output logic o_clk_synth_enable,
	output logic [1:0] o_oscillator_core_bias,
	output logic [1:0] o_amplifier_bias,
	output logic [1:0] o_mixer_bias,
	output logic o_input_attenuator,
	output logic o_vga_enable,
	output logic o_vga_auto_mode,
	output logic [2:0] o_agc_reference,
	output logic [13:0] o_clk_ref_divider,
	output logic [12:0] o_clk_feedback_divider,
	output logic o_clk_lock_fast_enable,
	output logic o_clk_pump_polarity,
	output logic [3:0] o_clk_pump_steps,
	output logic o_clk_test_mode,
	output logic [11:0] o_clk_fast_acquire,
	output logic [4:0] o_pos_cap_code,
	output logic [4:0] o_neg_cap_code,
	output logic o_pos_cap_range_error,
	output logic o_neg_cap_range_error
);
	localparam int PROD_W = COUNT_W + 8;

	// ----------------------------------------
	// Capacitor code arithmetic
	// ----------------------------------------
	// The needed capacitance scales with (oscillator rate / cutoff); the cutoff
	// is f_clk/3.2 * 0x60/code, so the code grows with count * response code.
	function automatic logic [5:0] cap_calc(input logic [COUNT_W-1:0] cnt,
		input logic [7:0] resp, input int shift, input int offset);
		logic [PROD_W-1:0] prod;
		logic [PROD_W-1:0] scaled;
		logic [PROD_W-1:0] off;
		prod = PROD_W'(cnt) * PROD_W'(resp);
		scaled = prod >> shift;
		off = PROD_W'(offset);
		if (scaled < off)
			cap_calc = {1'b1, 5'h00};
		else if (scaled - off > PROD_W'(`IFAAF_CAP_MAX))
			cap_calc = {1'b1, `IFAAF_CAP_MAX};
		else
			cap_calc = {1'b0, 5'((scaled - off))};
	endfunction

	// ----------------------------------------
	// Serial port
	// ----------------------------------------
	logic [6:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic [7:0] rdata;

	ifaaf_spi_slave u_spi (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_spi_cs_n(i_spi_cs_n),
		.i_spi_clk(i_spi_clk),
		.i_spi_mosi(i_spi_mosi),
		.i_rdata(rdata),
		.o_addr(addr),
		.o_wdata(wdata),
		.o_wr(wr),
		.o_miso(o_spi_miso),
		.o_miso_oe(o_spi_miso_oe)
	);

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	logic [7:0] sby_reg, sby_next;
	logic [5:0] bias_reg, bias_next;
	logic attn_reg, attn_next;
	logic [2:0] agc_ref_reg, agc_ref_next;
	logic [5:0] ref_hi_reg, ref_hi_next;
	logic [7:0] ref_lo_reg, ref_lo_next;
	logic [4:0] fb_hi_reg, fb_hi_next;
	logic [7:0] fb_lo_reg, fb_lo_next;
	logic [5:0] pump_reg, pump_next;
	logic [3:0] fa_hi_reg, fa_hi_next;
	logic [7:0] fa_lo_reg, fa_lo_next;

	always_comb
	begin
		sby_next = sby_reg;
		bias_next = bias_reg;
		attn_next = attn_reg;
		agc_ref_next = agc_ref_reg;
		ref_hi_next = ref_hi_reg;
		ref_lo_next = ref_lo_reg;
		fb_hi_next = fb_hi_reg;
		fb_lo_next = fb_lo_reg;
		pump_next = pump_reg;
		fa_hi_next = fa_hi_reg;
		fa_lo_next = fa_lo_reg;
		if (wr)
		begin
			if (addr == `IFAAF_ADDR_STANDBY)
				sby_next = wdata;
			else if (addr == `IFAAF_ADDR_BIAS)
				bias_next = wdata[`IFAAF_AMP_BIAS_HI:`IFAAF_OSC_BIAS_LO];
			else if (addr == `IFAAF_ADDR_ATTN)
				attn_next = wdata[`IFAAF_ATTN_BIT];
			else if (addr == `IFAAF_ADDR_AGC_REF)
				agc_ref_next = wdata[2:0];
			else if (addr == `IFAAF_ADDR_REF_HI)
				ref_hi_next = wdata[5:0];
			else if (addr == `IFAAF_ADDR_REF_LO)
				ref_lo_next = wdata;
			else if (addr == `IFAAF_ADDR_FB_HI)
				fb_hi_next = wdata[4:0];
			else if (addr == `IFAAF_ADDR_FB_LO)
				fb_lo_next = wdata;
			else if (addr == `IFAAF_ADDR_PUMP)
				pump_next = {wdata[`IFAAF_PUMP_FAST_BIT:`IFAAF_PUMP_CUR_LO],
					wdata[`IFAAF_PUMP_TEST_BIT]};
			else if (addr == `IFAAF_ADDR_FA_HI)
				fa_hi_next = wdata[3:0];
			else if (addr == `IFAAF_ADDR_FA_LO)
				fa_lo_next = wdata;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sby_reg <= `IFAAF_RST_STANDBY;
			bias_reg <= 6'h00;
			attn_reg <= 1'b0;
			agc_ref_reg <= 3'h0;
			ref_hi_reg <= 6'h00;
			ref_lo_reg <= `IFAAF_RST_REF_LO;
			fb_hi_reg <= 5'h00;
			fb_lo_reg <= `IFAAF_RST_FB_LO;
			pump_reg <= 6'h00;
			fa_hi_reg <= 4'h0;
			fa_lo_reg <= `IFAAF_RST_FA_LO;
		end
		else
		begin
			sby_reg <= sby_next;
			bias_reg <= bias_next;
			attn_reg <= attn_next;
			agc_ref_reg <= agc_ref_next;
			ref_hi_reg <= ref_hi_next;
			ref_lo_reg <= ref_lo_next;
			fb_hi_reg <= fb_hi_next;
			fb_lo_reg <= fb_lo_next;
			pump_reg <= pump_next;
			fa_hi_reg <= fa_hi_next;
			fa_lo_reg <= fa_lo_next;
		end
	end

	// ----------------------------------------
	// Filter tuning engine
	// ----------------------------------------
	ifaaf_tune_state_t state_reg, state_next;
	logic [7:0] resp_reg, resp_next;
	logic lock_reg, lock_next;
	logic [COUNT_W-1:0] meas_reg, meas_next;
	ifaaf_cap_t pos_reg, pos_next, neg_reg, neg_next;
	logic pos_err_reg, pos_err_next, neg_err_reg, neg_err_next;
	logic resp_wr, meter_done, meter_active;
	logic [COUNT_W-1:0] meter_count;
	logic [5:0] pos_calc, neg_calc;

	// writes after a zero write are ignored
	assign resp_wr = wr & (addr == `IFAAF_ADDR_FILT_RESP) & ~lock_reg;

	// edges of the RC oscillator counted in sampling-clock cycles
	ifaaf_rc_meter #(
		.WINDOW_CYCLES(WINDOW_CYCLES),
		.COUNT_W(COUNT_W)
	) u_meter (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_start(resp_wr),
		.i_rc_osc(i_rc_osc),
		.o_count(meter_count),
		.o_done(meter_done),
		.o_active(meter_active)
	);

	// both arrays from one measurement, code scales inversely to cutoff
	assign pos_calc = cap_calc(meas_reg, resp_reg, POS_SHIFT, POS_OFFSET);
	assign neg_calc = cap_calc(meas_reg, resp_reg, NEG_SHIFT, NEG_OFFSET);

	always_comb
	begin
		state_next = state_reg;
		resp_next = resp_reg;
		lock_next = lock_reg;
		meas_next = meas_reg;
		pos_next = pos_reg;
		neg_next = neg_reg;
		pos_err_next = pos_err_reg;
		neg_err_next = neg_err_reg;
		case (state_reg)
			TUNE_IDLE:
				state_next = TUNE_IDLE;
			TUNE_MEASURE:
				if (meter_done)
				begin
					meas_next = meter_count;
					state_next = TUNE_COMPUTE;
				end
			TUNE_COMPUTE:
			begin
				pos_next = pos_calc[4:0];
				neg_next = neg_calc[4:0];
				pos_err_next = pos_calc[5];
				neg_err_next = neg_calc[5];
				state_next = TUNE_IDLE;
			end
			default:
				state_next = TUNE_IDLE;
		endcase
		if (resp_wr)
		begin
			resp_next = wdata;
			// a zero write locks the register
			if (wdata == 8'h00)
				lock_next = 1'b1;
			// restart overrides a run in progress and clears flags
			pos_err_next = 1'b0;
			neg_err_next = 1'b0;
			// Codes of an aborted run are never loaded
			pos_next = pos_reg;
			neg_next = neg_reg;
			state_next = TUNE_MEASURE;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_reg <= TUNE_IDLE;
			resp_reg <= `IFAAF_RST_FILT_RESP;
			lock_reg <= 1'b0;
			meas_reg <= '0;
			pos_reg <= 5'h00;
			neg_reg <= 5'h00;
			pos_err_reg <= 1'b0;
			neg_err_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			resp_reg <= resp_next;
			lock_reg <= lock_next;
			meas_reg <= meas_next;
			pos_reg <= pos_next;
			neg_reg <= neg_next;
			pos_err_reg <= pos_err_next;
			neg_err_reg <= neg_err_next;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_comb
	begin
		if (addr == `IFAAF_ADDR_STANDBY)
			rdata = sby_reg;
		else if (addr == `IFAAF_ADDR_BIAS)
			rdata = {bias_reg, 2'h0};
		else if (addr == `IFAAF_ADDR_ATTN)
			rdata = {attn_reg, 7'h00};
		else if (addr == `IFAAF_ADDR_AGC_REF)
			rdata = {5'h00, agc_ref_reg};
		else if (addr == `IFAAF_ADDR_REF_HI)
			rdata = {2'h0, ref_hi_reg};
		else if (addr == `IFAAF_ADDR_REF_LO)
			rdata = ref_lo_reg;
		else if (addr == `IFAAF_ADDR_FB_HI)
			rdata = {3'h0, fb_hi_reg};
		else if (addr == `IFAAF_ADDR_FB_LO)
			rdata = fb_lo_reg;
		else if (addr == `IFAAF_ADDR_PUMP)
			rdata = {1'b0, pump_reg[5:1], 1'b0, pump_reg[0]};
		else if (addr == `IFAAF_ADDR_FA_HI)
			rdata = {4'h0, fa_hi_reg};
		else if (addr == `IFAAF_ADDR_FA_LO)
			rdata = fa_lo_reg;
		else if (addr == `IFAAF_ADDR_FILT_RESP)
			rdata = resp_reg;
		else if (addr == `IFAAF_ADDR_NEG_CAP)
			rdata = {2'h0, neg_err_reg, neg_reg};
		else if (addr == `IFAAF_ADDR_POS_CAP)
			rdata = {2'h0, pos_err_reg, pos_reg};
		else
			rdata = 8'h00;
	end

	// ----------------------------------------
	// Analog control outputs
	// ----------------------------------------
	assign o_standby_control = sby_reg;
	assign o_adc_enable = ~sby_reg[`IFAAF_SBY_ADC_BIT];
	// synthesizer off so an external clock source can be used
	assign o_clk_synth_enable = ~sby_reg[`IFAAF_SBY_CK_BIT];
	assign o_oscillator_core_bias = bias_reg[1:0];
	assign o_amplifier_bias = bias_reg[5:4];
	assign o_mixer_bias = bias_reg[3:2];
	assign o_input_attenuator = attn_reg;
	// standby wins over either gain mode
	assign o_vga_enable = ~sby_reg[`IFAAF_SBY_VGA_BIT];
	assign o_vga_auto_mode = (agc_ref_reg != 3'h0);
	assign o_agc_reference = agc_ref_reg;
	assign o_clk_ref_divider = {ref_hi_reg, ref_lo_reg};
	assign o_clk_feedback_divider = {fb_hi_reg, fb_lo_reg};
	assign o_clk_lock_fast_enable = pump_reg[5];
	assign o_clk_pump_polarity = pump_reg[4];
	// pump current in 0.625 mA units
	assign o_clk_pump_steps = {1'b0, pump_reg[3:1]} + 4'h1;
	assign o_clk_test_mode = pump_reg[0];
	assign o_clk_fast_acquire = {fa_hi_reg, fa_lo_reg};
	assign o_pos_cap_code = pos_reg;
	assign o_neg_cap_code = neg_reg;
	assign o_pos_cap_range_error = pos_err_reg;
	assign o_neg_cap_range_error = neg_err_reg;
	assign o_rc_osc_enable = meter_active;
	assign o_tuning_busy = (state_reg != TUNE_IDLE);
endmodule

//--- verif/ifaaf_top_chk.sv
// Port-level assertion checker for the IF front end top module
`timescale 1ns/100ps
module ifaaf_chk
#(
	parameter int WINDOW_CYCLES = 256
)
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic o_tuning_busy,
	input wire logic o_rc_osc_enable,
	input wire logic [7:0] o_standby_control,
	input wire logic o_clk_synth_enable,
	input wire logic o_vga_enable,
	input wire logic o_vga_auto_mode,
	input wire logic [2:0] o_agc_reference,
	input wire logic [3:0] o_clk_pump_steps,
	input wire logic [4:0] o_pos_cap_code,
	input wire logic [4:0] o_neg_cap_code,
	input wire logic o_pos_cap_range_error,
	input wire logic o_neg_cap_range_error
);
	// Slack covers the compute cycle and pin sync
	localparam int BUSY_MAX = WINDOW_CYCLES + 8;
	default clocking dc @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);
	synth_off_a: assert property (o_clk_synth_enable == !o_standby_control[5])
		else $error("synth enable");
	vga_off_a: assert property (o_vga_enable == !o_standby_control[2])
		else $error("vga enable");
	gain_mode_a: assert property (o_vga_auto_mode == (o_agc_reference != 3'h0))
		else $error("gain mode");
	pump_step_a: assert property (o_clk_pump_steps != 4'h0 && o_clk_pump_steps <= 4'h8)
		else $error("pump steps");
	busy_start_a: assert property ($rose(o_tuning_busy) |-> o_rc_osc_enable ##1 o_tuning_busy[*8])
		else $error("busy start");
	busy_bound_a: assert property ($rose(o_tuning_busy) |-> ##[1:BUSY_MAX] !o_tuning_busy)
		else $error("busy bound");
	osc_gate_a: assert property (o_rc_osc_enable |-> o_tuning_busy)
		else $error("osc gate");
	err_clear_a: assert property ($rose(o_tuning_busy) |-> ##1 (!o_pos_cap_range_error && !o_neg_cap_range_error))
		else $error("error clear");
	pos_sat_a: assert property (o_pos_cap_range_error |-> o_pos_cap_code inside {5'h00, 5'h1f})
		else $error("pos saturate");
	neg_sat_a: assert property (o_neg_cap_range_error |-> o_neg_cap_code inside {5'h00, 5'h1f})
		else $error("neg saturate");
	pos_load_a: assert property ($changed(o_pos_cap_code) |-> $fell(o_tuning_busy))
		else $error("pos load");
	neg_load_a: assert property ($changed(o_neg_cap_code) |-> $fell(o_tuning_busy))
		else $error("neg load");
endmodule

bind ifaaf_top ifaaf_chk #(.WINDOW_CYCLES(WINDOW_CYCLES)) u_chk (.i_mclk(i_mclk),
	.i_rst_n(i_rst_n), .o_tuning_busy(o_tuning_busy), .o_rc_osc_enable(o_rc_osc_enable),
	.o_standby_control(o_standby_control), .o_clk_synth_enable(o_clk_synth_enable),
	.o_vga_enable(o_vga_enable), .o_vga_auto_mode(o_vga_auto_mode),
	.o_agc_reference(o_agc_reference), .o_clk_pump_steps(o_clk_pump_steps),
	.o_pos_cap_code(o_pos_cap_code), .o_neg_cap_code(o_neg_cap_code),
	.o_pos_cap_range_error(o_pos_cap_range_error),
	.o_neg_cap_range_error(o_neg_cap_range_error));

//--- verif/ifaaf_host_model.sv
// Serial port host model driving register frames into the front end
`timescale 1ns/100ps
module ifaaf_host_model
(
	input wire logic i_mclk,
	output logic o_cs_n,
	output logic o_sclk,
	output logic o_mosi,
	input wire logic i_miso,
	input wire logic i_miso_oe
);
	initial
	begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_mosi = 1'b0;
	end
	// Six-cycle half period outlasts the pin synchronizer
	task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [15:0] f;
		f = {rw, a, d};
		q = 8'h00;
		@(posedge i_mclk);
		o_cs_n <= 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			o_mosi <= f[i];
			repeat (6) @(posedge i_mclk);
			o_sclk <= 1'b1;
			// Undriven line reads unknown so a missing enable cannot match
			if (i < 8)
				q[i] = i_miso_oe ? i_miso : 1'bx;
			repeat (6) @(posedge i_mclk);
			o_sclk <= 1'b0;
		end
		repeat (3) @(posedge i_mclk);
		o_cs_n <= 1'b1;
		o_mosi <= ~f[0];
		repeat (6) @(posedge i_mclk);
	endtask
endmodule

//--- verif/tb.sv
// Self-checking bench for the front end registers and filter tuning
`timescale 1ns/100ps
module tb;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic rc = 1'b0;
	int rc_div = 4;
	int rc_cnt = 0;
	int n_mismatch = 0;
	int comparisons = 0;
	logic [7:0] sh [0:31];
	logic [7:0] q;
	logic [7:0] d;
	logic [11:0] e;
	wire logic cs_n, sclk, mosi, miso, miso_oe;
	logic [6:0] al [16] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h06, 7'h10, 7'h11, 7'h12,
		7'h13, 7'h14, 7'h15, 7'h16, 7'h1c, 7'h1d, 7'h1e, 7'h7f};
	logic [7:0] rl [4] = '{8'h60, 8'hff, 8'h01, 8'h90};

	always #25 mclk = ~mclk;
	// Periodic oscillator gives an exact edge count per window
	always @(posedge mclk)
	begin
		rc_cnt <= (rc_cnt + 1) % rc_div;
		rc <= rc_cnt < rc_div / 2;
	end

	ifaaf_host_model host (.i_mclk(mclk), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi),
		.i_miso(miso), .i_miso_oe(miso_oe));
	ifaaf_top #(.WINDOW_CYCLES(32)) uut (.i_mclk(mclk), .i_rst_n(rst_n), .i_spi_cs_n(cs_n),
		.i_spi_clk(sclk), .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(miso_oe),
		.i_rc_osc(rc), .o_rc_osc_enable(), .o_tuning_busy(), .o_standby_control(),
		.o_adc_enable(), .o_clk_synth_enable(), .o_oscillator_core_bias(),
		.o_amplifier_bias(), .o_mixer_bias(), .o_input_attenuator(), .o_vga_enable(),
		.o_vga_auto_mode(), .o_agc_reference(), .o_clk_ref_divider(),
		.o_clk_feedback_divider(), .o_clk_lock_fast_enable(), .o_clk_pump_polarity(),
		.o_clk_pump_steps(), .o_clk_test_mode(), .o_clk_fast_acquire(), .o_pos_cap_code(),
		.o_neg_cap_code(), .o_pos_cap_range_error(), .o_neg_cap_range_error());

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		logic [7:0] x;
		host.xfer(1'b0, a, v, x);
	endtask
	task automatic rd(input logic [6:0] a);
		host.xfer(1'b1, a, 8'h00, q);
	endtask
	task automatic do_reset;
		rst_n <= 1'b0;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		foreach (sh[k])
			sh[k] = 8'h00;
		sh[0] = 8'hff;
		sh[17] = 8'h38;
		sh[19] = 8'h3c;
		sh[22] = 8'h04;
		@(posedge mclk);
	endtask
	function automatic logic [7:0] wmask(input logic [6:0] a);
		case (a)
			7'h00, 7'h11, 7'h13, 7'h16: return 8'hff;
			7'h01: return 8'hfc;
			7'h03: return 8'h80;
			7'h06: return 8'h07;
			7'h10: return 8'h3f;
			7'h12: return 8'h1f;
			7'h14: return 8'h7d;
			7'h15: return 8'h0f;
			default: return 8'h00;
		endcase
	endfunction
	function automatic logic [11:0] tune_exp(input int c, input logic [7:0] r);
		int v [2];
		logic [11:0] x;
		v[0] = ((c * r) >> 6) - 4;
		v[1] = ((c * r) >> 7) - 4;
		for (int k = 0; k < 2; k++)
			x[k*6 +: 6] = v[k] < 0 ? 6'h20 : v[k] > 31 ? 6'h3f : {1'b0, v[k][4:0]};
		return x;
	endfunction
	task automatic chk_ports;
		chk("standby", {uut.o_standby_control, uut.o_adc_enable, uut.o_clk_synth_enable,
			uut.o_vga_enable}, {sh[0], ~sh[0][3], ~sh[0][5], ~sh[0][2]});
		chk("bias", {uut.o_oscillator_core_bias, uut.o_amplifier_bias, uut.o_mixer_bias},
			{sh[1][3:2], sh[1][7:6], sh[1][5:4]});
		chk("gain", {uut.o_input_attenuator, uut.o_agc_reference, uut.o_vga_auto_mode},
			{sh[3][7], sh[6][2:0], |sh[6][2:0]});
		chk("div", {uut.o_clk_ref_divider, uut.o_clk_feedback_divider},
			{sh[16][5:0], sh[17], sh[18][4:0], sh[19]});
		chk("pump", {uut.o_clk_lock_fast_enable, uut.o_clk_pump_polarity, uut.o_clk_pump_steps,
			uut.o_clk_test_mode, uut.o_clk_fast_acquire}, {sh[20][6:5],
			{1'b0, sh[20][4:2]} + 4'h1, sh[20][0], sh[21][3:0], sh[22]});
	endtask
	task automatic wait_busy(input logic v);
		int n;
		n = 0;
		while (uut.o_tuning_busy !== v && n < 300)
		begin
			@(posedge mclk);
			n++;
		end
		chk("busy", uut.o_tuning_busy, v);
	endtask
	task automatic tune(input logic [7:0] r);
		wr(7'h1c, r);
		wait_busy(1'b1);
		chk("err", {uut.o_pos_cap_range_error, uut.o_neg_cap_range_error}, 2'b00);
		wait_busy(1'b0);
		e = tune_exp(32 / rc_div, r);
		chk("cap", {uut.o_neg_cap_range_error, uut.o_neg_cap_code, uut.o_pos_cap_range_error,
			uut.o_pos_cap_code}, e);
		rd(7'h1d);
		chk("neg", q, e[11:6]);
		rd(7'h1e);
		chk("pos", q, e[5:0]);
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial
	begin
		repeat (80000) @(posedge mclk);
		n_mismatch++;
		test_done;
	end
	initial
	begin
		void'($urandom(32'h86f4));
		do_reset;
		for (int r = 0; r < 4; r++)
		begin
			foreach (al[k])
			begin
				// Response register skipped here since a write starts tuning
				if (r > 0 && al[k] != 7'h1c)
				begin
					d = (r == 1 && al[k] == 7'h01) ? 8'hf0 : 8'($urandom);
					wr(al[k], d);
					if (al[k] < 7'h20)
						sh[al[k]] = d & wmask(al[k]);
				end
				rd(al[k]);
				chk("reg", q, al[k] < 7'h20 ? sh[al[k]] : 8'h00);
			end
			chk_ports;
		end
		wr(7'h00, 8'hfb);
		sh[0] = 8'hfb;
		chk_ports;
		wr(7'h00, 8'hff);
		sh[0] = 8'hff;
		chk_ports;
		for (int t = 0; t < 7; t++)
		begin
			rc_div <= 2 << ($urandom % 3);
			d = t < 4 ? rl[t] : 8'($urandom % 255 + 1);
			tune(d);
			rd(7'h1c);
			chk("resp", q, d);
		end
		tune(8'h00);
		wr(7'h1c, 8'h60);
		repeat (10) @(posedge mclk);
		chk("lock", uut.o_tuning_busy, 1'b0);
		rd(7'h1c);
		chk("resp", q, 8'h00);
		do_reset;
		wr(7'h1c, 8'h60);
		repeat (5) @(posedge mclk);
		do_reset;
		chk("abort", {uut.o_tuning_busy, uut.o_pos_cap_code}, 6'h00);
		tune(8'h60);
		rd(7'h1c);
		chk("resp", q, 8'h60);
		test_done;
	end
endmodule
